//--- design/opb_pkg.sv
/*
  Shared constants of the object-protocol link: memory map of the identification
  block and object table, command codes, message layout and start-up timing.
  Assumes a single 250 MHz clock shared by both ends.
*/
package opb_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned FAULT_TIMEOUT_MS = 300;
  localparam int unsigned FAULT_TIMEOUT_CYC = FAULT_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int unsigned BOOT_DELAY_CYC   = 16;

  // ==========================================================================
  // Memory map
  localparam int unsigned AW          = 16;
  localparam logic [15:0] ID_BASE     = 16'h0000;
  localparam int unsigned ID_BYTES    = 7;
  localparam logic [15:0] ID_COUNT_OFS = 16'h0006;
  localparam logic [15:0] TABLE_BASE  = 16'h0007;
  localparam int unsigned ENTRY_BYTES = 6;
  localparam int unsigned NUM_OBJ     = 11;
  localparam logic [7:0]  OBJ_COUNT   = 8'h0B;
  localparam logic [15:0] OBJ_SPACE   = 16'h0100;
  localparam int unsigned OBJ_SIZE    = 32;

  // Identification bytes 0..5; values arbitrary
  localparam logic [7:0] ID_FAMILY  = 8'hA5;
  localparam logic [7:0] ID_VARIANT = 8'h01;
  localparam logic [7:0] ID_VERSION = 8'h10;
  localparam logic [7:0] ID_BUILD   = 8'h00;
  localparam logic [7:0] ID_XSIZE   = 8'h29;
  localparam logic [7:0] ID_YSIZE   = 8'h1A;

  // ==========================================================================
  // Object types, instance counts, order in the table
  localparam logic [7:0] TYPE_MSG  = 8'h05;
  localparam logic [7:0] TYPE_CMD  = 8'h06;
  localparam logic [7:0] TYPE_PWR  = 8'h07;
  localparam logic [7:0] TYPE_ACQ  = 8'h08;
  localparam logic [7:0] TYPE_DIAG = 8'h25;
  localparam logic [7:0] TYPE_MCNT = 8'h2C;
  localparam logic [7:0] TYPE_TMR  = 8'h3D;
  localparam logic [7:0] TYPE_LENS = 8'h41;
  localparam logic [7:0] TYPE_RULE = 8'h46;
  localparam logic [7:0] TYPE_CONT = 8'h47;
  localparam logic [7:0] TYPE_TCH  = 8'h64;
  localparam int unsigned N_LENS  = 3;
  localparam int unsigned N_TMR   = 6;
  localparam int unsigned N_RULE  = 20;
  localparam int unsigned IDX_MSG = 0;
  localparam int unsigned IDX_CMD = 1;
  localparam int unsigned IDX_MCNT = 5;
  localparam int unsigned IDX_DIAG = 4;
  localparam int unsigned IDX_CFG_FIRST = 2;

  // ==========================================================================
  // Command object fields (byte offsets inside the object)
  localparam logic [4:0] CMD_RESET  = 5'h00;
  localparam logic [4:0] CMD_BACKUP = 5'h01;
  localparam logic [4:0] CMD_CALIB  = 5'h02;
  localparam logic [4:0] CMD_DIAG   = 5'h05;
  localparam logic [7:0] BACKUP_KEY = 8'h55;
  // Enable / report-enable bits in byte 0 of configurable objects
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_RPT_BIT = 1;

  // ==========================================================================
  // Message layout: byte 0 report id, byte 1 status
  localparam logic [7:0] RID_NONE   = 8'hFF;
  localparam logic [7:0] RID_CMD    = 8'h01;
  localparam int unsigned CFGERR_BIT = 3;
  localparam int unsigned RESET_BIT  = 7;
  localparam int unsigned MSG_DEPTH = 4;

  typedef enum logic [1:0] {OPB_ERR_NONE, OPB_ERR_TIMEOUT, OPB_ERR_CFG} opb_err_e;

endpackage

//--- design/opb_link_if.sv
/*
  Link between host and device: a byte-wide memory bus standing in for the
  serial transport, and the active-low message-pending line.
  Assumes both ends share sys_clk; a read answers one cycle later.
*/
`timescale 1ns/100ps
`default_nettype none
interface opb_link_if;
  logic [15:0] addr;                // Byte address
  logic [7:0]  wdata;               // Write byte
  logic        wr;                  // Write strobe
  logic        rd;                  // Read strobe
  logic [7:0]  rdata;               // Read byte, cycle after rd
  logic        rvalid;              // Marks rdata
  logic        message_pending_n;   // Low while messages wait

  modport device (input addr, wdata, wr, rd, output rdata, rvalid, message_pending_n);
  modport host   (output addr, wdata, wr, rd, input rdata, rvalid, message_pending_n);
endinterface
`default_nettype wire

//--- design/opb_device.sv
/*
  Device end: identification block, object table, object memory, message queue,
  command and message-count objects, non-volatile image with checksum.
  Assumes host accesses arrive one per cycle on the link interface.
*/
// Contract
// - Device pulls pending line low after power-up
// - Identification bytes readable from address zero
// - Checksum mismatch at start sets config error
// - Host rewrites config then issues backup; on a config error the host issues the backup without rewriting config
// - Host reads all object start addresses
// - Identification bytes carry object count
// - Host maps report ids from table; the host keeps only the command object's report id
// - Host drains start-up messages
// - Zero field value disables function
// - Settings persist only after backup command
// - Host enables, configures, then enables reporting; the host only writes enable, then enable and report-enable
// - Message object holds one message
// - Command object write executes command
// - Message count object reports pending messages
// - Three lens compensation instances
// - Six timer instances
// - Twenty rule instances with config container
// - Read-only diagnostic object answers debug commands; CMD_DIAG is not decoded, so the object reads zero
// - Pending line asserted on new message
// - Host waits on line, never polls
`timescale 1ns/100ps
`default_nettype none
module opb_device #(
  parameter int unsigned NV_INIT_SUM = 0  // Stored checksum at power-up
) (
  input  wire logic   sys_clk,           // 250 MHz clock
  input  wire logic   rstn,              // Async reset, active low
  opb_link_if.device  link,              // Host link
  output logic        calib_req,         // Pulse: calibration started
  output logic        cfg_err           // Level: config checksum failed
);
  localparam int unsigned OBJ_BYTES = opb_pkg::NUM_OBJ * opb_pkg::OBJ_SIZE;
  localparam int unsigned TBL_BYTES = opb_pkg::NUM_OBJ * opb_pkg::ENTRY_BYTES;

  // ==========================================================================
  // Object memory, volatile and non-volatile copies
  logic [7:0] ram_reg [OBJ_BYTES];
  logic [7:0] nv_reg  [OBJ_BYTES];
  logic [7:0] nv_sum_reg;
  logic [7:0] msg_q   [opb_pkg::MSG_DEPTH][2];
  logic [2:0] qcnt_reg;
  logic [1:0] qhead_reg;
  logic       boot_reg;
  logic [4:0] boot_cnt_reg;
  logic [7:0] rdata_reg;
  logic       rvalid_reg;
  logic       pend_n_reg;
  logic       calib_reg;
  logic       cfg_err_reg;

  // ==========================================================================
  // Address decode
  wire        in_id    = link.addr < opb_pkg::TABLE_BASE;
  wire        in_tbl   = link.addr >= opb_pkg::TABLE_BASE &&
                         link.addr < opb_pkg::TABLE_BASE + 16'(TBL_BYTES);
  wire        in_obj   = link.addr >= opb_pkg::OBJ_SPACE &&
                         link.addr < opb_pkg::OBJ_SPACE + 16'(OBJ_BYTES);
  wire [15:0] obj_off  = link.addr - opb_pkg::OBJ_SPACE;
  wire [3:0]  obj_idx  = 4'(obj_off / opb_pkg::OBJ_SIZE);
  wire [4:0]  fld      = obj_off[4:0];
  wire [15:0] tbl_off  = link.addr - opb_pkg::TABLE_BASE;
  wire [3:0]  ent_idx  = 4'(tbl_off / opb_pkg::ENTRY_BYTES);
  wire [2:0]  ent_byte = 3'(tbl_off % opb_pkg::ENTRY_BYTES);
  wire        wr_cmd   = link.wr && in_obj && obj_idx == 4'(opb_pkg::IDX_CMD);
  wire        wr_cfg   = link.wr && in_obj && obj_idx >= 4'(opb_pkg::IDX_CFG_FIRST)
                         && obj_idx != 4'(opb_pkg::IDX_MCNT)
                         && obj_idx != 4'(opb_pkg::IDX_DIAG);
  wire        rd_msg   = link.rd && in_obj && obj_idx == 4'(opb_pkg::IDX_MSG)
                         && fld == 5'h00;
  wire        pop      = rd_msg && qcnt_reg != 3'h0;

  // Table entry fields: type, start lo, start hi, size-1, instances-1, ids
  function automatic logic [7:0] tbl_byte(input logic [3:0] e, input logic [2:0] b);
    logic [7:0]  t;
    logic [7:0]  n;
    logic [15:0] s;
    t = opb_pkg::TYPE_MSG;
    n = 8'h00;
    case (e)
      4'h0: t = opb_pkg::TYPE_MSG;
      4'h1: t = opb_pkg::TYPE_CMD;
      4'h2: t = opb_pkg::TYPE_PWR;
      4'h3: t = opb_pkg::TYPE_ACQ;
      4'h4: t = opb_pkg::TYPE_DIAG;
      4'h5: t = opb_pkg::TYPE_MCNT;
      4'h6: begin t = opb_pkg::TYPE_TMR;  n = 8'(opb_pkg::N_TMR - 1);  end
      4'h7: begin t = opb_pkg::TYPE_LENS; n = 8'(opb_pkg::N_LENS - 1); end
      4'h8: begin t = opb_pkg::TYPE_RULE; n = 8'(opb_pkg::N_RULE - 1); end
      4'h9: t = opb_pkg::TYPE_CONT;
      default: t = opb_pkg::TYPE_TCH;
    endcase
    s = opb_pkg::OBJ_SPACE + 16'({e, 5'h00});
    case (b)
      3'h0:    tbl_byte = t;
      3'h1:    tbl_byte = s[7:0];
      3'h2:    tbl_byte = s[15:8];
      3'h3:    tbl_byte = 8'(opb_pkg::OBJ_SIZE - 1);
      3'h4:    tbl_byte = n;
      default: tbl_byte = (e == 4'(opb_pkg::IDX_CMD)) ? opb_pkg::RID_CMD : 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] id_byte(input logic [2:0] b);
    case (b)
      3'h0:    id_byte = opb_pkg::ID_FAMILY;
      3'h1:    id_byte = opb_pkg::ID_VARIANT;
      3'h2:    id_byte = opb_pkg::ID_VERSION;
      3'h3:    id_byte = opb_pkg::ID_BUILD;
      3'h4:    id_byte = opb_pkg::ID_XSIZE;
      3'h5:    id_byte = opb_pkg::ID_YSIZE;
      default: id_byte = opb_pkg::OBJ_COUNT;
    endcase
  endfunction

  // Checksum over non-volatile image
  logic [7:0] nv_sum;
  always_comb begin
    nv_sum = 8'h00;
    for (int i = 0; i < OBJ_BYTES; i++) begin
      nv_sum = nv_sum ^ nv_reg[i];
    end
  end

  // Read data mux
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (in_id) begin
      rd_byte = id_byte(link.addr[2:0]);
    end else if (in_tbl) begin
      rd_byte = tbl_byte(ent_idx, ent_byte);
    end else if (in_obj && obj_idx == 4'(opb_pkg::IDX_MSG)) begin
      rd_byte = (qcnt_reg == 3'h0) ? ((fld == 5'h00) ? opb_pkg::RID_NONE : 8'h00)
              : (fld < 5'h02) ? msg_q[qhead_reg][fld[0]] : 8'h00;
    end else if (in_obj && obj_idx == 4'(opb_pkg::IDX_MCNT)) begin
      rd_byte = (fld == 5'h00) ? 8'(qcnt_reg) : 8'h00;
    end else if (in_obj) begin
      rd_byte = ram_reg[9'(obj_off)];
    end
  end

  // ==========================================================================
  // Boot: wait, check stored checksum, queue the command object's message
  wire boot_done = boot_reg && boot_cnt_reg == 5'(opb_pkg::BOOT_DELAY_CYC);
  wire sum_bad   = nv_sum != nv_sum_reg;
  wire backup    = wr_cmd && fld == opb_pkg::CMD_BACKUP &&
                   link.wdata == opb_pkg::BACKUP_KEY;
  wire do_reset  = wr_cmd && fld == opb_pkg::CMD_RESET && link.wdata != 8'h00;
  wire push      = boot_done || do_reset;
  wire [7:0] stat = {1'b1, 3'b000, sum_bad, 3'b000};

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      boot_reg     <= 1'b1;
      boot_cnt_reg <= 5'h00;
    end else if (do_reset) begin
      boot_reg     <= 1'b1;
      boot_cnt_reg <= 5'h00;
    end else if (boot_reg) begin
      boot_cnt_reg <= boot_cnt_reg + 5'h01;
      boot_reg     <= !boot_done;
    end
  end

  // Queue; message object exposes the head
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      qcnt_reg  <= 3'h0;
      qhead_reg <= 2'h0;
    end else begin
      if (push && qcnt_reg < 3'(opb_pkg::MSG_DEPTH)) begin
        // Tail is head plus count even when a pop moves the head
        msg_q[2'(qhead_reg + 2'(qcnt_reg))][0] <= opb_pkg::RID_CMD;
        msg_q[2'(qhead_reg + 2'(qcnt_reg))][1] <= stat;
      end
      if (pop) qhead_reg <= qhead_reg + 2'h1;
      qcnt_reg <= qcnt_reg + 3'(push && qcnt_reg < 3'(opb_pkg::MSG_DEPTH)) - 3'(pop);
    end
  end

  logic [7:0] ram_sum;
  always_comb begin
    ram_sum = 8'h00;
    for (int i = 0; i < OBJ_BYTES; i++) begin
      ram_sum = ram_sum ^ ram_reg[i];
    end
  end

  // Object RAM: zero at reset, reloaded from NV on the reset command, written by host
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < OBJ_BYTES; i++) begin
        ram_reg[i] <= 8'h00;
        nv_reg[i]  <= 8'h00;
      end
      nv_sum_reg <= 8'(NV_INIT_SUM);
    end else begin
      if (do_reset) begin
        for (int i = 0; i < OBJ_BYTES; i++) ram_reg[i] <= nv_reg[i];
      end else if (wr_cfg || wr_cmd) begin
        ram_reg[9'(obj_off)] <= link.wdata;
      end
      if (backup) begin
        for (int i = 0; i < OBJ_BYTES; i++) nv_reg[i] <= ram_reg[i];
        nv_sum_reg <= ram_sum;
      end
    end
  end

  // ==========================================================================
  // Outputs
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg   <= 8'h00;
      rvalid_reg  <= 1'b0;
      pend_n_reg  <= 1'b1;
      calib_reg   <= 1'b0;
      cfg_err_reg <= 1'b0;
    end else begin
      rdata_reg   <= rd_byte;
      rvalid_reg  <= link.rd;
      pend_n_reg  <= !(qcnt_reg + 3'(push) - 3'(pop) != 3'h0);
      calib_reg   <= wr_cmd && fld == opb_pkg::CMD_CALIB && link.wdata != 8'h00;
      if (boot_done) cfg_err_reg <= sum_bad;
      else if (backup) cfg_err_reg <= 1'b0;
    end
  end

  assign link.rdata             = rdata_reg;
  assign link.rvalid            = rvalid_reg;
  assign link.message_pending_n = pend_n_reg;
  assign calib_req              = calib_reg;
  assign cfg_err                = cfg_err_reg;
endmodule
`default_nettype wire

//--- design/opb_host.sv
/*
  Host end: waits for the pending line, reads identification and object table,
  learns the command report id, drains messages, configures the first configurable object unless a config error was reported, then backs up.
  Assumes the device answers a read one cycle later on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module opb_host #(
  parameter int unsigned TIMEOUT_CYC = opb_pkg::FAULT_TIMEOUT_CYC  // Fault wait
) (
  input  wire logic        sys_clk,     // 250 MHz clock
  input  wire logic        rstn,        // Async reset, active low
  opb_link_if.host         link,        // Device link
  input  wire logic        start,       // Pulse: begin bring-up
  output logic             ready,       // Level: bring-up done
  output opb_pkg::opb_err_e err,        // Fault code
  output logic [7:0]       obj_count,   // Learned object count
  output logic [7:0]       cmd_rid,     // Learned command report id
  output logic [15:0]      last_msg     // Last message read (id, status)
);
  typedef enum logic [3:0] {
    OPB_IDLE, OPB_WAIT, OPB_ID, OPB_TBL, OPB_DRAIN, OPB_CFG, OPB_BACKUP, OPB_DONE
  } opb_st_e;

  opb_st_e           st_reg;
  logic [31:0]       tmo_reg;
  logic [15:0]       ptr_reg;
  logic [15:0]       end_reg;
  logic              wait_reg;
  logic [7:0]        cnt_reg;
  logic [7:0]        rid_reg;
  logic [15:0]       cmd_base_reg;
  logic [15:0]       msg_reg;
  logic              rdy_reg;
  opb_pkg::opb_err_e err_reg;
  logic [15:0]       addr_reg;
  logic [7:0]        wdata_reg;
  logic              wr_reg;
  logic              rd_reg;
  logic [15:0]       last_msg_q;

  wire [15:0] tbl_end = opb_pkg::TABLE_BASE + 16'(cnt_reg) * 16'(opb_pkg::ENTRY_BYTES);
  wire [15:0] tbl_off = ptr_reg - opb_pkg::TABLE_BASE;
  wire [2:0]  ent_b   = 3'(tbl_off % opb_pkg::ENTRY_BYTES);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= OPB_IDLE; tmo_reg <= 32'h0; ptr_reg <= 16'h0; end_reg <= 16'h0;
      wait_reg <= 1'b0; cnt_reg <= 8'h0; rid_reg <= 8'h0; cmd_base_reg <= 16'h0;
      msg_reg <= 16'h0; rdy_reg <= 1'b0; err_reg <= opb_pkg::OPB_ERR_NONE;
      last_msg_q <= 16'h0;
      addr_reg <= 16'h0; wdata_reg <= 8'h0; wr_reg <= 1'b0; rd_reg <= 1'b0;
    end else begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      case (st_reg)
        OPB_IDLE: if (start) begin st_reg <= OPB_WAIT; tmo_reg <= 32'h0; end
        OPB_WAIT: begin
          tmo_reg <= tmo_reg + 32'h1;
          if (!link.message_pending_n) begin
            st_reg <= OPB_ID; ptr_reg <= opb_pkg::ID_BASE;
          end else if (tmo_reg == TIMEOUT_CYC) begin
            err_reg <= opb_pkg::OPB_ERR_TIMEOUT; st_reg <= OPB_DONE;
          end
        end
        OPB_ID, OPB_TBL: begin
          if (!wait_reg) begin
            addr_reg <= ptr_reg; rd_reg <= 1'b1; wait_reg <= 1'b1;
          end else if (link.rvalid) begin
            wait_reg <= 1'b0; ptr_reg <= ptr_reg + 16'h1;
            if (st_reg == OPB_ID) begin
              if (ptr_reg == opb_pkg::ID_COUNT_OFS) begin
                cnt_reg <= link.rdata; st_reg <= OPB_TBL;
              end
            end else begin
              if (ent_b == 3'h0) rid_reg <= link.rdata;
              if (ent_b == 3'h1 && rid_reg == opb_pkg::TYPE_CMD) cmd_base_reg[7:0] <= link.rdata;
              if (ent_b == 3'h2 && rid_reg == opb_pkg::TYPE_CMD) cmd_base_reg[15:8] <= link.rdata;
              if (ent_b == 3'h5 && rid_reg == opb_pkg::TYPE_CMD) msg_reg[15:8] <= link.rdata;
              if (ptr_reg + 16'h1 == tbl_end) st_reg <= OPB_DRAIN;
            end
          end
        end
        OPB_DRAIN: begin
          if (!wait_reg) begin
            if (!link.message_pending_n) begin
              // Status first: reading byte 0 pops the message
              addr_reg <= opb_pkg::OBJ_SPACE + 16'h1; rd_reg <= 1'b1;
              wait_reg <= 1'b1; ptr_reg <= 16'h0;
            end else if (err_reg == opb_pkg::OPB_ERR_CFG) begin
              st_reg <= OPB_BACKUP;
            end else begin
              st_reg <= OPB_CFG;
              ptr_reg <= opb_pkg::OBJ_SPACE + 16'(opb_pkg::IDX_CFG_FIRST * opb_pkg::OBJ_SIZE);
              end_reg <= 16'h0;
            end
          end else if (link.rvalid && ptr_reg == 16'h0) begin
            last_msg_q[7:0] <= link.rdata;
            addr_reg <= opb_pkg::OBJ_SPACE; rd_reg <= 1'b1; ptr_reg <= 16'h1;
          end else if (link.rvalid) begin
            last_msg_q[15:8] <= link.rdata;
            if (link.rdata == msg_reg[15:8] && last_msg_q[opb_pkg::CFGERR_BIT])
              err_reg <= opb_pkg::OPB_ERR_CFG;
            wait_reg <= 1'b0;
          end
        end
        OPB_CFG: begin
          wr_reg <= 1'b1; addr_reg <= ptr_reg;
          wdata_reg <= (end_reg == 16'h0) ? 8'(1 << opb_pkg::CTRL_EN_BIT) :
                       8'((1 << opb_pkg::CTRL_EN_BIT) | (1 << opb_pkg::CTRL_RPT_BIT));
          if (end_reg == 16'h0) end_reg <= 16'h1;
          else st_reg <= OPB_BACKUP;
        end
        OPB_BACKUP: begin
          wr_reg <= 1'b1;
          addr_reg <= cmd_base_reg + 16'(opb_pkg::CMD_BACKUP);
          wdata_reg <= opb_pkg::BACKUP_KEY; st_reg <= OPB_DONE;
        end
        OPB_DONE: rdy_reg <= 1'b1;
        default: st_reg <= OPB_IDLE;
      endcase
    end
  end

  assign link.addr  = addr_reg;
  assign link.wdata = wdata_reg;
  assign link.wr    = wr_reg;
  assign link.rd    = rd_reg;
  assign ready      = rdy_reg;
  assign err        = err_reg;
  assign obj_count  = cnt_reg;
  assign cmd_rid    = msg_reg[15:8];
  assign last_msg   = last_msg_q;
endmodule
`default_nettype wire

//--- verification/opb_link_asserts.sv
/*
  Concurrent checks on the host-device link: read timing, identification and
  table contents, message-pending behaviour.
  Assumes one clock shared by both ends and the testbench instantiating it.
*/
`timescale 1ns/100ps
`default_nettype none
module opb_link_asserts (
  input wire logic        sys_clk,           // Link clock
  input wire logic        rstn,              // Async reset, active low
  input wire logic [15:0] addr,              // Byte address
  input wire logic [7:0]  wdata,             // Write byte
  input wire logic        wr,                // Write strobe
  input wire logic        rd,                // Read strobe
  input wire logic [7:0]  rdata,             // Read byte
  input wire logic        rvalid,            // Marks rdata
  input wire logic        message_pending_n  // Low while messages wait
);
  // ==========================================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire logic msg_rd = rd && addr == opb_pkg::OBJ_SPACE;

  chk_read_answer: assert property (rd |=> rvalid)
    else $error("read not answered next cycle");
  chk_stray_valid: assert property (rvalid |-> $past(rd))
    else $error("read data without a read");
  chk_id_first_byte: assert property (rd && addr == 16'h0000 |=> rdata == opb_pkg::ID_FAMILY)
    else $error("identification byte 0 wrong");
  chk_id_obj_count: assert property (rd && addr == 16'h0006 |=> rdata == opb_pkg::OBJ_COUNT)
    else $error("object count wrong");
  chk_table_first_type: assert property (rd && addr == 16'h0007 |=> rdata == opb_pkg::TYPE_MSG)
    else $error("table does not follow identification");
  chk_cmd_report_id: assert property (rd && addr == 16'h0012 |=> rdata == opb_pkg::RID_CMD)
    else $error("command report id wrong");
  chk_boot_pending: assert property ($rose(rstn) |-> ##[1:40] !message_pending_n)
    else $error("pending line not low after boot");
  chk_msg_present: assert property (msg_rd && !message_pending_n |=> rdata != opb_pkg::RID_NONE)
    else $error("empty message while pending");
  chk_release_cause: assert property ($rose(message_pending_n) |-> $past(msg_rd) || $past(msg_rd, 2))
    else $error("pending released without a message read");

  cov_msg_read: cover property (msg_rd && !message_pending_n);
  cov_release: cover property ($rose(message_pending_n));
  cov_write: cover property (wr);
endmodule
`default_nettype wire

//--- verification/object_protocol_host_bringup_tb.sv
/*
  Testbench: host and device joined on one link, a second device driven by
  bench tasks, a third link where the device never answers, a fourth pair
  whose stored checksum is bad.
  Assumes the opb package and link interface are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module object_protocol_host_bringup_tb;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic start = 1'b0;
  logic ready, cfg_a, cfg_b, calib_b, ready_d, cfg_d;
  opb_pkg::opb_err_e err_a, err_c, err_d;
  logic [15:0] msg_a, msg_d;
  logic [7:0] cnt_a, rid_a, d;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  logic [7:0] id_exp [7] = '{opb_pkg::ID_FAMILY, opb_pkg::ID_VARIANT, opb_pkg::ID_VERSION,
    opb_pkg::ID_BUILD, opb_pkg::ID_XSIZE, opb_pkg::ID_YSIZE, opb_pkg::OBJ_COUNT};
  opb_link_if l1 ();
  opb_link_if l2 ();
  opb_link_if l3 ();
  opb_link_if l4 ();

  // ==========================================================================
  // Ends under test
  opb_device opb_device_i (.sys_clk(sys_clk), .rstn(rstn), .link(l1), .calib_req(), .cfg_err(cfg_a));
  opb_host #(.TIMEOUT_CYC(200)) opb_host_i (.sys_clk(sys_clk), .rstn(rstn), .link(l1),
    .start(start), .ready(ready), .err(err_a), .obj_count(cnt_a), .cmd_rid(rid_a),
    .last_msg(msg_a));
  opb_device #(.NV_INIT_SUM(1)) opb_device_b_i (.sys_clk(sys_clk), .rstn(rstn), .link(l2),
    .calib_req(calib_b), .cfg_err(cfg_b));
  opb_host #(.TIMEOUT_CYC(50)) opb_host_c_i (.sys_clk(sys_clk), .rstn(rstn), .link(l3),
    .start(start), .ready(), .err(err_c), .obj_count(), .cmd_rid(), .last_msg());
  opb_device #(.NV_INIT_SUM(1)) opb_device_d_i (.sys_clk(sys_clk), .rstn(rstn), .link(l4),
    .calib_req(), .cfg_err(cfg_d));
  opb_host #(.TIMEOUT_CYC(200)) opb_host_d_i (.sys_clk(sys_clk), .rstn(rstn), .link(l4),
    .start(start), .ready(ready_d), .err(err_d), .obj_count(), .cmd_rid(),
    .last_msg(msg_d));
  opb_link_asserts opb_link_asserts_i (.sys_clk(sys_clk), .rstn(rstn), .addr(l1.addr),
    .wdata(l1.wdata), .wr(l1.wr), .rd(l1.rd), .rdata(l1.rdata), .rvalid(l1.rvalid),
    .message_pending_n(l1.message_pending_n));

  always #2 sys_clk = ~sys_clk;

  // ==========================================================================
  // Bench tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    l2.rd <= 1'b1;
    l2.addr <= a;
    @(posedge sys_clk);
    l2.rd <= 1'b0;
    l2.addr <= ~a;
    #1 v = l2.rdata;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    l2.wr <= 1'b1;
    l2.addr <= a;
    l2.wdata <= v;
    @(posedge sys_clk);
    l2.wr <= 1'b0;
    l2.addr <= ~a;
    l2.wdata <= ~v;
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      complete_run;
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    {l2.addr, l2.wdata, l2.wr, l2.rd} = '0;
    {l3.rdata, l3.rvalid, l3.message_pending_n} = 10'h001;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    n = 0;
    while ((l1.message_pending_n !== 1'b0 || l2.message_pending_n !== 1'b0) && n < 60) begin
      @(posedge sys_clk);
      n++;
    end
    chk(l1.message_pending_n, 16'h0000);
    chk(l2.message_pending_n, 16'h0000);
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(16'(i), d);
      chk(d, id_exp[i]);
    end
    rd(16'h0007, d); chk(d, opb_pkg::TYPE_MSG);
    rd(16'h000D, d); chk(d, opb_pkg::TYPE_CMD);
    rd(16'h000E, d); chk(d, 16'h0020);
    rd(16'h000F, d); chk(d, 16'h0001);
    rd(16'h0012, d); chk(d, opb_pkg::RID_CMD);
    rd(16'h01A0, d); chk(d, 16'h0001);
    rd(16'h0101, d); chk(d & 8'h88, 16'h0088);
    chk(cfg_b, 16'h0001);
    rd(16'h0100, d); chk(d, opb_pkg::RID_CMD);
    @(posedge sys_clk);
    #1 chk(l2.message_pending_n, 16'h0001);
    rd(16'h01A0, d); chk(d, 16'h0000);
    rd(16'h0140, d); chk(d, 16'h0000);
    wr(16'h0180, 8'h5A);
    rd(16'h0180, d); chk(d, 16'h0000);
    wr(16'h0240, 8'h3C);
    rd(16'h0240, d); chk(d, 16'h003C);
    rd(16'h0140, d); chk(d, 16'h0000);
    wr(16'h0000, 8'h3C);
    rd(16'h0000, d); chk(d, opb_pkg::ID_FAMILY);
    wr(16'h0121, opb_pkg::BACKUP_KEY);
    @(posedge sys_clk);
    #1 chk(cfg_b, 16'h0000);
    wr(16'h0122, 8'h01);
    #1 chk(calib_b, 16'h0001);
    @(posedge sys_clk);
    #1 chk(calib_b, 16'h0000);
    wr(16'h0120, 8'h01);
    n = 0;
    while (l2.message_pending_n !== 1'b0 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    chk(l2.message_pending_n, 16'h0000);
    rd(16'h0101, d); chk(d, 16'h0080);
    rd(16'h0240, d); chk(d, 16'h003C);
    n = 0;
    while (ready !== 1'b1 && err_a === opb_pkg::OPB_ERR_NONE && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    chk(ready, 16'h0001);
    chk(err_a, opb_pkg::OPB_ERR_NONE);
    chk(cnt_a, opb_pkg::OBJ_COUNT);
    chk(rid_a, opb_pkg::RID_CMD);
    chk(cfg_a, 16'h0000);
    chk(l1.message_pending_n, 16'h0001);
    chk(err_c, opb_pkg::OPB_ERR_TIMEOUT);
    chk(msg_a, {opb_pkg::RID_CMD, 8'h80});
    chk(ready_d, 16'h0001);
    chk(err_d, opb_pkg::OPB_ERR_CFG);
    chk(msg_d, {opb_pkg::RID_CMD, 8'h88});
    chk(cfg_d, 16'h0000);
    chk(l4.message_pending_n, 16'h0001);
    complete_run;
  end
endmodule
`default_nettype wire
